/* File: pkg/eoc_consts.svh */
// Constants for the external oscillator control block
`ifndef EOC_CONSTS_SVH
`define EOC_CONSTS_SVH
`define EOC_SFR_ADDR        8'h9F
`define EOC_SFR_PAGE        8'h0F
`define EOC_CTRL_RESET      8'h00
`define EOC_VALID_BIT       7
`define EOC_MODE_MSB        6
`define EOC_MODE_LSB        4
`define EOC_UNUSED_BIT      3
`define EOC_FREQ_MSB        2
`define EOC_FREQ_LSB        0
`define EOC_MUL_INT_X2      2'h0
`define EOC_MUL_EXT_X2      2'h1
`define EOC_MUL_INT_X4      2'h2
`define EOC_MUL_EXT_X4      2'h3
`define EOC_MAX_SYSCLK_MHZ  50
`endif

/* File: pkg/eoc_pkg.sv */
// Types for the external oscillator control block
package eoc_pkg;
  typedef enum logic [2:0] {
    EOC_MODE_OFF     = 3'h0,
    EOC_MODE_CMOS    = 3'h2,
    EOC_MODE_CMOS_D2 = 3'h3,
    EOC_MODE_RC      = 3'h4,
    EOC_MODE_CAP     = 3'h5,
    EOC_MODE_XTAL    = 3'h6,
    EOC_MODE_XTAL_D2 = 3'h7
  } eoc_mode_t;

  typedef struct packed {
    logic       osc_enable;
    logic       crystal_en;
    logic       div2_en;
    logic [2:0] freq_code;
  } eoc_analog_ctl_t;

  typedef struct packed {
    logic       ext_source;
    logic [2:0] mult_factor;
    logic       use_divide;
  } eoc_mult_ctl_t;

  typedef struct packed {
    logic crystal_pin_a_claim;
    logic crystal_pin_b_claim;
    logic pin_a_analog;
    logic pin_b_analog;
  } eoc_pin_claim_t;
endpackage

/* File: verilog/eoc_ctrl.sv */
// External oscillator control register, mode decode, multiplier source decode
// Behaviour
// - Select 11 feeds external oscillator times four
// - Select 01 external x2; 10 internal x4
// - Times-two sources ignore the divide field
// - Bit 7 read-only crystal valid flag
// - Bits 6:4 select oscillator mode
// - Bits 2:0 hold frequency control code
// - Register at 0x9F page 0x0F, resets zero
// - Crystal modes claim P0.2 and P0.3
// - Capacitor, RC, CMOS claim only P0.3
`timescale 1ns/1ps
`include "eoc_consts.svh"

module eoc_ctrl (
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  input  wire logic [7:0]              sfr_addr,
  input  wire logic [7:0]              sfr_page,
  input  wire logic                    sfr_wr,
  input  wire logic                    sfr_rd,
  input  wire logic [7:0]              sfr_wdata,
  output logic      [7:0]              sfr_rdata,
  output logic                         sfr_hit,
  input  wire logic                    crystal_stable,
  input  wire logic [1:0]              multiplier_source_select,
  output eoc_pkg::eoc_analog_ctl_t     analog_ctl,
  output eoc_pkg::eoc_mult_ctl_t       mult_ctl,
  output eoc_pkg::eoc_pin_claim_t      pin_claim
);
  import eoc_pkg::*;

  localparam logic [7:0] CTRL_RESET = `EOC_CTRL_RESET;

  logic [2:0] mode_q;
  logic [2:0] freq_q;
  logic       valid_q;
  logic       sel_w;
  logic       wr_hit;
  logic       rd_hit;
  logic [2:0] wr_mode;
  logic [2:0] wr_freq;
  logic       is_xtal;
  logic       osc_on;
  logic       div2_sel;
  logic       one_pin;
  logic       b_analog;
  logic       valid_rd;

  assign sel_w   = (sfr_addr == `EOC_SFR_ADDR) && (sfr_page == `EOC_SFR_PAGE);
  assign wr_hit  = sel_w && sfr_wr;
  assign rd_hit  = sel_w && sfr_rd;
  assign sfr_hit = wr_hit || rd_hit;

  assign wr_mode = sfr_wdata[`EOC_MODE_MSB:`EOC_MODE_LSB];
  assign wr_freq = sfr_wdata[`EOC_FREQ_MSB:`EOC_FREQ_LSB];

  // mode field, frequency code, reset zero
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mode_q <= CTRL_RESET[`EOC_MODE_MSB:`EOC_MODE_LSB];
      freq_q <= CTRL_RESET[`EOC_FREQ_MSB:`EOC_FREQ_LSB];
    end else if (wr_hit) begin
      mode_q <= wr_mode;
      freq_q <= wr_freq;
    end
  end

  // valid only tracks stability in crystal modes
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= is_xtal && crystal_stable;
    end
  end

  // flag reads zero outside crystal modes
  assign valid_rd = valid_q && is_xtal;

  always_comb begin
    osc_on   = 1'b0;
    is_xtal  = 1'b0;
    div2_sel = 1'b0;
    one_pin  = 1'b0;
    b_analog = 1'b0;
    unique case (mode_q)
      EOC_MODE_OFF: begin
        osc_on   = 1'b0;
        is_xtal  = 1'b0;
        div2_sel = 1'b0;
        one_pin  = 1'b0;
        b_analog = 1'b0;
      end
      EOC_MODE_CMOS: begin
        osc_on   = 1'b1;
        is_xtal  = 1'b0;
        div2_sel = 1'b0;
        one_pin  = 1'b1;
        b_analog = 1'b0;
      end
      EOC_MODE_CMOS_D2: begin
        osc_on   = 1'b1;
        is_xtal  = 1'b0;
        div2_sel = 1'b1;
        one_pin  = 1'b1;
        b_analog = 1'b0;
      end
      EOC_MODE_RC: begin
        osc_on   = 1'b1;
        is_xtal  = 1'b0;
        div2_sel = 1'b0;
        one_pin  = 1'b1;
        b_analog = 1'b1;
      end
      EOC_MODE_CAP: begin
        osc_on   = 1'b1;
        is_xtal  = 1'b0;
        div2_sel = 1'b0;
        one_pin  = 1'b1;
        b_analog = 1'b1;
      end
      EOC_MODE_XTAL: begin
        osc_on   = 1'b1;
        is_xtal  = 1'b1;
        div2_sel = 1'b0;
        one_pin  = 1'b0;
        b_analog = 1'b1;
      end
      EOC_MODE_XTAL_D2: begin
        osc_on   = 1'b1;
        is_xtal  = 1'b1;
        div2_sel = 1'b1;
        one_pin  = 1'b0;
        b_analog = 1'b1;
      end
      default: begin
        osc_on   = 1'b0;
        is_xtal  = 1'b0;
        div2_sel = 1'b0;
        one_pin  = 1'b0;
        b_analog = 1'b0;
      end
    endcase
  end

  // read data with unused bit at zero
  always_comb begin
    sfr_rdata = 8'h00;
    if (rd_hit) begin
      sfr_rdata[`EOC_VALID_BIT]                = valid_rd;
      sfr_rdata[`EOC_MODE_MSB:`EOC_MODE_LSB]   = mode_q;
      sfr_rdata[`EOC_UNUSED_BIT]               = 1'b0;
      sfr_rdata[`EOC_FREQ_MSB:`EOC_FREQ_LSB]   = freq_q;
    end
  end

  // off mode keeps drive circuit disabled
  always_comb begin
    analog_ctl.osc_enable = osc_on;
    analog_ctl.crystal_en = is_xtal;
    analog_ctl.div2_en    = div2_sel;
    // frequency band code to the analog cell
    analog_ctl.freq_code  = freq_q;
  end

  // crystal claims both pins; one-pin modes claim P0.3
  always_comb begin
    pin_claim.crystal_pin_a_claim = is_xtal;
    pin_claim.crystal_pin_b_claim = is_xtal || one_pin;
    pin_claim.pin_a_analog        = is_xtal;
    pin_claim.pin_b_analog        = b_analog;
  end

  always_comb begin
    mult_ctl.ext_source  = 1'b0;
    mult_ctl.mult_factor = 3'h2;
    mult_ctl.use_divide  = 1'b0;
    unique case (multiplier_source_select)
      `EOC_MUL_INT_X2: begin
        mult_ctl.ext_source  = 1'b0;
        mult_ctl.mult_factor = 3'h2;
        mult_ctl.use_divide  = 1'b0;
      end
      `EOC_MUL_EXT_X2: begin
        mult_ctl.ext_source  = 1'b1;
        mult_ctl.mult_factor = 3'h2;
        mult_ctl.use_divide  = 1'b0;
      end
      `EOC_MUL_INT_X4: begin
        mult_ctl.ext_source  = 1'b0;
        mult_ctl.mult_factor = 3'h4;
        mult_ctl.use_divide  = 1'b1;
      end
      `EOC_MUL_EXT_X4: begin
        mult_ctl.ext_source  = 1'b1;
        mult_ctl.mult_factor = 3'h4;
        mult_ctl.use_divide  = 1'b1;
      end
    endcase
  end
endmodule

/* File: verif/eoc_ctrl_properties.sv */
// Checker for the external oscillator control block
`timescale 1ns/1ps
module eoc_ctrl_properties import eoc_pkg::*; (
  input wire logic            clk_sys,
  input wire logic            reset_n,
  input wire logic            sfr_wr,
  input wire logic [7:0]      sfr_wdata,
  input wire logic [7:0]      sfr_rdata,
  input wire logic            sfr_hit,
  input wire logic            crystal_stable,
  input wire logic [1:0]      multiplier_source_select,
  input wire eoc_analog_ctl_t analog_ctl,
  input wire eoc_mult_ctl_t   mult_ctl,
  input wire eoc_pin_claim_t  pin_claim
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_idle_read: assert property (!sfr_hit |-> !sfr_rdata) else $error("stray data");
  a_freq_write: assert property (sfr_hit && sfr_wr |=>
    analog_ctl.freq_code == $past(sfr_wdata[2:0])) else $error("freq not stored");
  a_mode_write: assert property (sfr_hit && sfr_wr |=>
    analog_ctl.crystal_en == ($past(sfr_wdata[6:5]) == 2'h3)) else $error("mode not stored");
  a_valid_flag: assert property (sfr_rdata[7] |-> sfr_rdata[6:5] == 2'h3 &&
    $past(crystal_stable)) else $error("bad valid flag");
  a_xtal_pins: assert property (pin_claim.crystal_pin_a_claim == analog_ctl.crystal_en)
    else $error("pin a claim");
  a_osc_pin: assert property (pin_claim.crystal_pin_b_claim == analog_ctl.osc_enable)
    else $error("pin b claim");
  a_ext_x4: assert property (multiplier_source_select == 2'h3 |-> mult_ctl == 5'h19)
    else $error("ext x4");
  a_ext_x2: assert property (multiplier_source_select == 2'h1 |-> mult_ctl == 5'h14)
    else $error("ext x2");
  a_int_x4: assert property (multiplier_source_select == 2'h2 |-> mult_ctl == 5'h09)
    else $error("int x4");
  a_unused_zero: assert property (!sfr_rdata[3]) else $error("unused bit set");
  a_reset_off: assert property (!$past(reset_n) |-> !analog_ctl.osc_enable &&
    pin_claim == 4'h0) else $error("not off after reset");
  cover property (sfr_hit && sfr_wr);
  cover property (sfr_rdata[7]);
  cover property (multiplier_source_select == 2'h3);
  cover property (pin_claim.crystal_pin_b_claim && !pin_claim.crystal_pin_a_claim);
endmodule
bind eoc_ctrl eoc_ctrl_properties u_props (
  .clk_sys                  (clk_sys),
  .reset_n                  (reset_n),
  .sfr_wr                   (sfr_wr),
  .sfr_wdata                (sfr_wdata),
  .sfr_rdata                (sfr_rdata),
  .sfr_hit                  (sfr_hit),
  .crystal_stable           (crystal_stable),
  .multiplier_source_select (multiplier_source_select),
  .analog_ctl               (analog_ctl),
  .mult_ctl                 (mult_ctl),
  .pin_claim                (pin_claim)
);

/* File: verif/eoc_xtal_model.sv */
// Crystal model whose amplitude settles after a delay
`timescale 1ns/1ps
module eoc_xtal_model #(parameter int SETTLE = 8) (
  input  wire logic clk_sys,
  input  wire logic drive_en,
  output logic      stable
);
  int cnt = 0;
  always_ff @(posedge clk_sys) cnt <= drive_en ? cnt + 1 : 0;
  assign stable = drive_en && cnt >= SETTLE;
endmodule

/* File: verif/test_external_oscillator_control.sv */
// Bench for the external oscillator control block
`timescale 1ns/1ps
module test_external_oscillator_control;
  import eoc_pkg::*;
  logic            clk_sys = 0, reset_n = 0, sfr_wr = 0, sfr_rd = 0, sfr_hit, xs;
  logic [7:0]      sfr_addr = 8'h9F, sfr_page = 8'h0F, sfr_wdata = 8'h00, sfr_rdata, d, e;
  logic [1:0]      msel = 2'h0;
  logic [31:0]     seed = 32'h00001FCC;
  eoc_analog_ctl_t actl;
  eoc_mult_ctl_t   mctl;
  eoc_pin_claim_t  pins;
  int              fail_count = 0, total_checks = 0;
  always #50 clk_sys = ~clk_sys;
  eoc_ctrl u_eoc_ctrl (.clk_sys, .reset_n, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .sfr_hit, .crystal_stable(xs), .multiplier_source_select(msel),
    .analog_ctl(actl), .mult_ctl(mctl), .pin_claim(pins));
  eoc_xtal_model u_eoc_xtal_model (.clk_sys, .drive_en(actl.crystal_en), .stable(xs));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] exp_pins(input logic [2:0] m);
    return {m > 5, m > 1, m > 5, m > 3};
  endfunction
  function automatic logic [4:0] exp_mult(input logic [1:0] s);
    return {s[0], s[1] ? 3'h4 : 3'h2, s[1]};
  endfunction
  function automatic logic [5:0] exp_actl(input logic [2:0] m, f);
    return {m > 1, m > 5, m == 3 || m == 7, f};
  endfunction
  task automatic chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1;
    @(posedge clk_sys) #5;
    sfr_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, v);
    sfr_addr = a;
    sfr_rd = 1;
    #10 chk(sfr_rdata, v);
    chk({7'h0, sfr_hit}, {7'h0, a == 8'h9F && sfr_page == 8'h0F});
    @(posedge clk_sys) #5;
    sfr_rd = 0;
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    #5 reset_n = 1;
    chk({4'h0, pins}, 8'h00);
    chk({2'h0, actl}, 8'h00);
    rd(8'h9F, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      d = 8'(rnd());
      d[6:4] = i[2:0];
      msel = 2'(rnd());
      wr(8'h9F, d);
      chk({3'h0, mctl}, {3'h0, exp_mult(msel)});
      rd(8'h9E, 8'h00);
      repeat (10) @(posedge clk_sys);
      #5 chk({4'h0, pins}, {4'h0, exp_pins(d[6:4])});
      chk({2'h0, actl}, {2'h0, exp_actl(d[6:4], d[2:0])});
      e = {d[6:5] == 2'h3 && xs, d[6:4], 1'b0, d[2:0]};
      rd(8'h9F, e);
      sfr_page = 8'h0E;
      wr(8'h9F, ~d);
      rd(8'h9F, 8'h00);
      sfr_page = 8'h0F;
      wr(8'h9E, ~d);
      rd(8'h9F, e);
      $display("mode test %0d done", i);
    end
    summarize();
  end
endmodule
